// ===== pkg/spb_map.svh
/*
 * Bit positions, register codes, reset values and timing counts of the
 * synthesizer programming register bank.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SPB_MAP_SVH
`define SPB_MAP_SVH

// ----------------------------------------------------------------
// word select codes
// ----------------------------------------------------------------
`define SPB_SHIFT_W         24
`define SPB_SEL_CHANNEL     3'h0
`define SPB_SEL_MODREF      3'h1
`define SPB_SEL_PHASE       3'h2
`define SPB_SEL_FUNCTION    3'h3
`define SPB_SEL_FASTLOCK    3'h4
`define SPB_SEL_POWERDOWN   3'h5
`define SPB_SEL_OUTSEL      3'h6
`define SPB_SEL_TESTMODE    3'h7

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SPB_INT_HI          22
`define SPB_INT_LO          15
`define SPB_FRACTION_NUMERATOR_HI         14
`define SPB_FRACTION_NUMERATOR_LO         3
`define SPB_BOOST_BIT       23
`define SPB_REFHALF_BIT     22
`define SPB_PRESC_BIT       20
`define SPB_DOUBLER_BIT     19
`define SPB_RCNT_HI         18
`define SPB_RCNT_LO         15
`define SPB_MOD_HI          14
`define SPB_MOD_LO          3
`define SPB_PHASE_HI        14
`define SPB_PHASE_LO        3
`define SPB_PUMPGND_BIT     5
`define SPB_POLARITY_BIT    3
`define SPB_TMR_HI          13
`define SPB_TMR_LO          5
`define SPB_TSEL_HI         4
`define SPB_TSEL_LO         3
`define SPB_PWR_HI          7
`define SPB_PWR_LO          3
`define SPB_MODES_HI        15
`define SPB_MODES_LO        12
`define SPB_MUXSEL_HI       6
`define SPB_MUXSEL_LO       3

// ----------------------------------------------------------------
// reset values and timing counts
// ----------------------------------------------------------------
`define SPB_INT_RST         8'h00
`define SPB_FRACTION_NUMERATOR_RST        12'h000
`define SPB_MOD_RST         12'h000
`define SPB_RCNT_RST        4'h0
`define SPB_PHASE_RST       12'h000
`define SPB_TMR_RST         9'h000
`define SPB_PWR_RST         5'h00
`define SPB_NIB_RST         4'h0
`define SPB_TICK_LAST       2'h3
`define SPB_PUMP_CELLS_MAX  7'h40
`define SPB_PUMP_CELLS_MIN  7'h01

`endif

// ===== pkg/spb_pkg.sv
/*
 * Types of the synthesizer programming register bank.
 * Assumes spb_map.svh is on the include path.
 */
`include "spb_map.svh"

package spb_pkg;

	// fast-lock timer that a timer word write loads
	typedef enum logic [1:0] {
		SPB_TSEL_SWITCH_AB,
		SPB_TSEL_SWITCH_C,
		SPB_TSEL_PUMP,
		SPB_TSEL_NONE
	} spb_tsel_t;

	// serial receiver state
	typedef struct packed {
		logic                     clk_s1;
		logic                     clk_s2;
		logic                     clk_s3;
		logic                     dat_s1;
		logic                     dat_s2;
		logic                     stb_s1;
		logic                     stb_s2;
		logic                     stb_s3;
		logic [`SPB_SHIFT_W-1:0]  shift;
		logic                     valid;
		logic [`SPB_SHIFT_W-1:0]  word;
	} spb_rx_state_t;

	// register bank state
	typedef struct packed {
		logic        pd_s1;
		logic        pd_s2;
		logic        pd_s3;
		logic        pending;
		logic [7:0]  hold_int;
		logic [11:0] hold_fraction_numerator;
		logic [11:0] hold_mod;
		logic [3:0]  hold_rcnt;
		logic        hold_refhalf;
		logic        hold_doubler;
		logic        hold_boost;
		logic [11:0] hold_phase;
		logic [7:0]  int_value;
		logic [11:0] fraction_numerator;
		logic [11:0] fractional_modulus;
		logic [3:0]  ref_count;
		logic        ref_half;
		logic        doubler_en;
		logic        pump_current_boost;
		logic [11:0] phase_seed;
		logic        prescaler_sel;
		logic        pump_output_ground;
		logic        pd_polarity;
		logic [4:0]  power_bits;
		logic [3:0]  lock_modes;
		logic [3:0]  mux_sel;
		logic [8:0]  tmr_pump;
		logic [8:0]  tmr_ab;
		logic [8:0]  tmr_c;
		logic [8:0]  cnt_pump;
		logic [8:0]  cnt_ab;
		logic [8:0]  cnt_c;
		logic [1:0]  tick_div;
		logic [6:0]  pump_cells;
		logic        fast_lock;
		logic        filter_switch_a;
		logic        filter_switch_b;
		logic        filter_switch_c;
		logic        update;
	} spb_bank_state_t;

endpackage

// ===== pkg/spb_word_if.sv
/*
 * Carrier of latched serial words from the receiver to the bank.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`include "spb_map.svh"

interface spb_word_if;
	logic                     valid;
	logic [`SPB_SHIFT_W-1:0]  word;

	modport src (output valid, output word);
	modport dst (input valid, input word);
endinterface

// ===== core/spb_serial_rx.sv
/*
 * Three-wire serial receiver: synchronises the pins, shifts data and
 * presents a whole word for one cycle on each latch strobe rise.
 * Assumes the host holds data stable around each serial clock rise and
 * that serial clock and data pass equal synchroniser depth.
 */
`timescale 1ns/10ps
`include "spb_map.svh"

module spb_serial_rx
	import spb_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst_n,
	input  wire logic  ce,
	input  wire logic  sclk,
	input  wire logic  sdata,
	input  wire logic  latch_strobe,
	spb_word_if.src    out
);

	spb_rx_state_t q;
	spb_rx_state_t d;
	logic          clk_rise;
	logic          stb_rise;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.clk_s1 = sclk;
		d.clk_s2 = q.clk_s1;
		d.clk_s3 = q.clk_s2;
		d.dat_s1 = sdata;
		d.dat_s2 = q.dat_s1;
		d.stb_s1 = latch_strobe;
		d.stb_s2 = q.stb_s1;
		d.stb_s3 = q.stb_s2;
		clk_rise = q.clk_s2 & ~q.clk_s3;
		stb_rise = q.stb_s2 & ~q.stb_s3;
		d.valid = 1'b0;
		// data enters at the bottom so the first bit ends up as the msb
		if (clk_rise) begin
			d.shift = {q.shift[`SPB_SHIFT_W-2:0], q.dat_s2};
		end
		// shorter words leave their stale upper bits, which the bank ignores
		if (stb_rise) begin
			d.valid = 1'b1;
			d.word  = q.shift;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign out.valid = q.valid;
	assign out.word  = q.word;

endmodule

// ===== core/spb_bank.sv
/*
 * Programming register bank of a fractional-N synthesizer: eight
 * write-only control words, double buffering, channel update timing and
 * fast-lock timers.
 * Assumes the phase-detector reference arrives as a pin far slower than
 * clk (at least four clk periods per level) and the host drives the
 * serial pins.
 */
`timescale 1ns/10ps
`include "spb_map.svh"

module spb_bank
	import spb_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic         sclk,
	input  wire logic         sdata,
	input  wire logic         latch_strobe,
	input  wire logic         phase_detector,
	output logic [7:0]        int_value,
	output logic [11:0]       fraction_numerator,
	output logic [11:0]       fractional_modulus,
	output logic [3:0]        ref_count,
	output logic              ref_half,
	output logic              doubler_en,
	output logic              prescaler_sel,
	output logic              pump_current_boost,
	output logic [11:0]       phase_seed,
	output logic              pump_output_ground,
	output logic              pd_polarity,
	output logic [4:0]        power_bits,
	output logic [3:0]        lock_modes,
	output logic [3:0]        mux_sel,
	output logic              fast_lock,
	output logic [6:0]        pump_cells,
	output logic              filter_switch_a,
	output logic              filter_switch_b,
	output logic              filter_switch_c,
	output logic              channel_update
);

	spb_word_if            wbus ();
	spb_bank_state_t       q;
	spb_bank_state_t       d;
	logic                  pd_edge;
	logic                  tick;
	logic [2:0]            sel;
	logic [`SPB_SHIFT_W-1:0] w;
	spb_tsel_t             tsel;

	// ----------------------------------------------------------------
	// serial receiver
	// ----------------------------------------------------------------
	spb_serial_rx u_rx (
		.clk          (clk),
		.rst_n        (rst_n),
		.ce           (ce),
		.sclk         (sclk),
		.sdata        (sdata),
		.latch_strobe (latch_strobe),
		.out          (wbus.src)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.update = 1'b0;
		w    = wbus.word;
		sel  = w[2:0];
		tsel = spb_tsel_t'(w[`SPB_TSEL_HI:`SPB_TSEL_LO]);
		// reference pin synchroniser, edge taken after the second stage
		d.pd_s1 = phase_detector;
		d.pd_s2 = q.pd_s1;
		d.pd_s3 = q.pd_s2;
		pd_edge = q.pd_s2 & ~q.pd_s3;
		tick    = pd_edge && (q.tick_div == `SPB_TICK_LAST);

		// word decode; three lsbs pick the destination
		if (wbus.valid) begin
			case (sel)
				`SPB_SEL_CHANNEL: begin
					d.hold_int  = w[`SPB_INT_HI:`SPB_INT_LO];
					d.hold_fraction_numerator = w[`SPB_FRACTION_NUMERATOR_HI:`SPB_FRACTION_NUMERATOR_LO];
				end
				`SPB_SEL_MODREF: begin
					// buffered fields wait for the channel word
					d.hold_boost   = w[`SPB_BOOST_BIT];
					d.hold_refhalf = w[`SPB_REFHALF_BIT];
					d.hold_doubler = w[`SPB_DOUBLER_BIT];
					d.hold_rcnt    = w[`SPB_RCNT_HI:`SPB_RCNT_LO];
					d.hold_mod     = w[`SPB_MOD_HI:`SPB_MOD_LO];
					d.prescaler_sel = w[`SPB_PRESC_BIT]; // not buffered
				end
				`SPB_SEL_PHASE: begin
					d.hold_phase = w[`SPB_PHASE_HI:`SPB_PHASE_LO];
				end
				`SPB_SEL_FUNCTION: begin
					d.pump_output_ground = w[`SPB_PUMPGND_BIT];
					d.pd_polarity        = w[`SPB_POLARITY_BIT];
				end
				`SPB_SEL_FASTLOCK: begin
					case (tsel)
						SPB_TSEL_SWITCH_AB: d.tmr_ab   = w[`SPB_TMR_HI:`SPB_TMR_LO];
						SPB_TSEL_SWITCH_C:  d.tmr_c    = w[`SPB_TMR_HI:`SPB_TMR_LO];
						SPB_TSEL_PUMP:      d.tmr_pump = w[`SPB_TMR_HI:`SPB_TMR_LO];
						default:            d.tmr_pump = q.tmr_pump;
					endcase
				end
				`SPB_SEL_POWERDOWN: begin
					d.power_bits = w[`SPB_PWR_HI:`SPB_PWR_LO];
				end
				`SPB_SEL_OUTSEL: begin
					d.lock_modes = w[`SPB_MODES_HI:`SPB_MODES_LO];
					d.mux_sel    = w[`SPB_MUXSEL_HI:`SPB_MUXSEL_LO];
				end
				default: begin
					// test word carries nothing that this bank acts on
					d.pending = q.pending;
				end
			endcase
		end

		// a channel write in the same cycle as the consuming edge survives
		d.pending = (q.pending & ~pd_edge) |
			(wbus.valid && (sel == `SPB_SEL_CHANNEL));

		if (pd_edge && q.pending) begin
			// channel update: divider, buffered settings and timers together
			d.int_value          = q.hold_int;
			d.fraction_numerator = q.hold_fraction_numerator;
			d.fractional_modulus = q.hold_mod;
			d.ref_count          = q.hold_rcnt;
			d.ref_half           = q.hold_refhalf;
			d.doubler_en         = q.hold_doubler;
			d.pump_current_boost = q.hold_boost;
			d.phase_seed         = q.hold_phase;
			d.cnt_pump   = q.tmr_pump;
			d.cnt_ab     = q.tmr_ab;
			d.cnt_c      = q.tmr_c;
			d.tick_div   = 2'h0;
			d.pump_cells = `SPB_PUMP_CELLS_MAX;
			d.update     = 1'b1;
		end else if (pd_edge) begin
			// timers run at a quarter of the phase-detector rate
			d.tick_div = q.tick_div + 2'h1;
			if (tick) begin
				if (q.cnt_pump != 9'h000) begin
					d.cnt_pump = q.cnt_pump - 9'h001;
				end else if (q.pump_cells > `SPB_PUMP_CELLS_MIN) begin
					// halving per tick keeps the loop stable during the step-down
					d.pump_cells = {1'b0, q.pump_cells[6:1]};
				end
				if (q.cnt_ab != 9'h000) begin
					d.cnt_ab = q.cnt_ab - 9'h001;
				end
				if (q.cnt_c != 9'h000) begin
					d.cnt_c = q.cnt_c - 9'h001;
				end
			end
		end

		// switch levels follow the counters so a zero timer never closes a switch; fast_lock also covers the update cycle
		d.fast_lock       = d.update | (d.cnt_pump != 9'h000);
		d.filter_switch_a = d.cnt_ab != 9'h000;
		d.filter_switch_b = d.cnt_ab != 9'h000;
		d.filter_switch_c = d.cnt_c != 9'h000;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			q <= '0;
			q.pump_cells <= `SPB_PUMP_CELLS_MIN;
		end else if (ce) begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from state flops
	// ----------------------------------------------------------------
	assign int_value          = q.int_value;
	assign fraction_numerator = q.fraction_numerator;
	assign fractional_modulus = q.fractional_modulus;
	assign ref_count          = q.ref_count;
	assign ref_half           = q.ref_half;
	assign doubler_en         = q.doubler_en;
	assign prescaler_sel      = q.prescaler_sel;
	assign pump_current_boost = q.pump_current_boost;
	assign phase_seed         = q.phase_seed;
	assign pump_output_ground = q.pump_output_ground;
	assign pd_polarity        = q.pd_polarity;
	assign power_bits         = q.power_bits;
	assign lock_modes         = q.lock_modes;
	assign mux_sel            = q.mux_sel;
	assign fast_lock          = q.fast_lock;
	assign pump_cells         = q.pump_cells;
	assign filter_switch_a    = q.filter_switch_a;
	assign filter_switch_b    = q.filter_switch_b;
	assign filter_switch_c    = q.filter_switch_c;
	assign channel_update     = q.update;

endmodule

// ===== dv/spb_bank_checker.sv
/* Assertions on the pins of the synthesizer register bank.
   Assumes one clock domain and is bound to every spb_bank. */
`timescale 1ns/10ps
`include "spb_map.svh"
module spb_bank_checker
	import spb_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        latch_strobe,
	input wire logic        phase_detector,
	input wire logic [7:0]  int_value,
	input wire logic [11:0] fraction_numerator,
	input wire logic [11:0] fractional_modulus,
	input wire logic [3:0]  ref_count,
	input wire logic        ref_half,
	input wire logic        doubler_en,
	input wire logic        pump_current_boost,
	input wire logic [11:0] phase_seed,
	input wire logic [4:0]  power_bits,
	input wire logic [3:0]  mux_sel,
	input wire logic        fast_lock,
	input wire logic [6:0]  pump_cells,
	input wire logic        filter_switch_a,
	input wire logic        filter_switch_b,
	input wire logic        filter_switch_c,
	input wire logic        channel_update
);
	// ----------------------------------------------------------------
	// channel update, fast lock and direct words
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// every value that may only move at a channel update
	logic [50:0] snap;
	assign snap = {int_value, fraction_numerator, fractional_modulus, ref_count,
		ref_half, doubler_en, pump_current_boost, phase_seed};
	// pin is slow, so it is still high two cycles back
	sequence s_pd_seen;
		$past(phase_detector, 2);
	endsequence
	sequence s_fast_burst;
		fast_lock && pump_cells == `SPB_PUMP_CELLS_MAX && filter_switch_a
			&& filter_switch_b && filter_switch_c;
	endsequence
	property p_update_pd;
		channel_update |-> s_pd_seen;
	endproperty
	a_update_pd: assert property (p_update_pd) else $error("update without reference rise");
	property p_update_pulse;
		channel_update |=> !channel_update;
	endproperty
	a_update_pulse: assert property (p_update_pulse) else $error("update pulse too long");
	property p_update_burst;
		channel_update |-> s_fast_burst;
	endproperty
	a_update_burst: assert property (p_update_burst) else $error("fast lock not entered");
	property p_held;
		!channel_update |-> $stable(snap);
	endproperty
	a_held: assert property (p_held) else $error("buffered value moved early");
	property p_lock_max;
		fast_lock |-> pump_cells == `SPB_PUMP_CELLS_MAX;
	endproperty
	a_lock_max: assert property (p_lock_max) else $error("pump below maximum in fast lock");
	property p_lock_start;
		$rose(fast_lock) |-> channel_update;
	endproperty
	a_lock_start: assert property (p_lock_start) else $error("fast lock without update");
	property p_pump_halve;
		$changed(pump_cells) && !channel_update |-> pump_cells == ($past(pump_cells) >> 1);
	endproperty
	a_pump_halve: assert property (p_pump_halve) else $error("pump step not a halving");
	property p_switch_start;
		$rose(filter_switch_a) || $rose(filter_switch_c) |-> channel_update;
	endproperty
	a_switch_start: assert property (p_switch_start) else $error("switch closed off update");
	property p_switch_pair;
		filter_switch_a == filter_switch_b;
	endproperty
	a_switch_pair: assert property (p_switch_pair) else $error("shared switch timer split");
	// direct words only move a few cycles after a latch rise
	property p_direct_latch;
		$changed({power_bits, mux_sel}) |-> $past(latch_strobe, 3);
	endproperty
	a_direct_latch: assert property (p_direct_latch) else $error("word changed without latch");
endmodule

bind spb_bank spb_bank_checker spb_bank_checker_inst (.*);

// ===== dv/spb_host_model.sv
/* Host side of the three-wire programming link.
   Assumes the bench calls send and that pins idle with clock low. */
`timescale 1ns/10ps
module spb_host_model (
	output logic sclk,
	output logic sdata,
	output logic latch_strobe
);
	initial begin
		sclk = 1'b0;
		sdata = 1'b0;
		latch_strobe = 1'b0;
	end
	// link clock 125 ns, stands low between frames
	task automatic send(input logic [23:0] w, input int n);
		// quarter-ns skew keeps every pin change off the 8 ns clock edges
		#0.25;
		for (int i = n - 1; i >= 0; i--) begin
			sdata = w[i];
			#62.5 sclk = 1'b1;
			#62.5 sclk = 1'b0;
		end
		// released data line carries no stale value
		sdata = ~sdata;
		#62.5 latch_strobe = 1'b1;
		#62.5 latch_strobe = 1'b0;
		// trimmed so that a whole frame still lasts a multiple of half a ns
		#62.25;
	endtask
endmodule

// ===== dv/test_synth_program_register_bank.sv
/* Self-checking bench of the register bank.
   Assumes the host model drives the link and the bench the reference. */
`timescale 1ns/10ps
module test_synth_program_register_bank
	import spb_pkg::*;
;
	logic        clk, rst_n, ce, phase_detector, sclk, sdata, latch_strobe;
	logic [7:0]  int_value;
	logic [11:0] fraction_numerator, fractional_modulus, phase_seed;
	logic [3:0]  ref_count, lock_modes, mux_sel;
	logic [4:0]  power_bits;
	logic [6:0]  pump_cells;
	logic        ref_half, doubler_en, prescaler_sel, pump_current_boost;
	logic        pump_output_ground, pd_polarity, fast_lock, channel_update;
	logic        filter_switch_a, filter_switch_b, filter_switch_c;
	logic [50:0] exp_q[$];
	logic [50:0] act;
	logic [50:0] snap;
	logic [14:0] imm;
	int          seed = 76171;
	int          errors = 0;
	int          checks = 0;
	int          lock_n = 0;
	int          swab_n = 0;
	int          swc_n = 0;

	spb_bank spb_bank_inst (.*);
	spb_host_model spb_host_model_inst (.*);

	assign snap = {int_value, fraction_numerator, fractional_modulus, ref_count,
		ref_half, doubler_en, pump_current_boost, phase_seed};
	assign imm = {pump_output_ground, pd_polarity, power_bits, lock_modes, mux_sel};

	// ----------------------------------------------------------------
	// compare and close
	// ----------------------------------------------------------------
	task automatic chk_snap(input string nm, input logic [50:0] e, input logic [50:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic chk_field(input string nm, input logic [15:0] e, input logic [15:0] g);
		chk_snap(nm, {35'h0, e}, {35'h0, g});
	endtask
	task automatic wrap_up;
		if (errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		return $random(seed);
	endfunction

	// clock, slow reference, watchdog (run needs about 80 us)
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		phase_detector = 1'b0;
		forever begin
			repeat (5) @(posedge clk);
			#1 phase_detector = ~phase_detector;
		end
	end
	initial begin
		#400000;
		errors++;
		wrap_up;
	end

	// result monitor: oldest note against each update
	always @(posedge clk) begin
		if (channel_update === 1'b1) begin
			chk_snap("channel", exp_q.size() > 0 ? exp_q.pop_front() : 'x, snap);
			chk_field("boost cells", 16'h0040, {9'h0, pump_cells});
		end
	end

	// fast-lock and switch lengths in clk: timer x 4 reference rises x 10 clk
	always @(posedge clk) begin
		if (fast_lock === 1'b1) begin
			lock_n++;
		end else if (lock_n != 0) begin
			chk_field("lock length", 16'h0050, 16'(lock_n));
			lock_n = 0;
		end
		if (filter_switch_a === 1'b1 && filter_switch_b === 1'b1) begin
			swab_n++;
		end else if (swab_n != 0) begin
			chk_field("switch ab length", 16'h0168, 16'(swab_n));
			swab_n = 0;
		end
		if (filter_switch_c === 1'b1) begin
			swc_n++;
		end else if (swc_n != 0) begin
			chk_field("switch c length", 16'h0168, 16'(swc_n));
			swc_n = 0;
		end
	end

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic [11:0] md, fr, ph;
		logic [7:0]  iv;
		logic [18:0] mr;
		rst_n = 1'b0;
		ce = 1'b1;
		act = '0;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		@(posedge clk);
		chk_snap("reset", '0, snap);
		chk_field("reset cells", 16'h0001, {9'h0, pump_cells});
		// timers: switch ab, switch c, pump, ignored select
		for (int k = 0; k < 4; k++)
			spb_host_model_inst.send({9'h0, 1'b1, (k == 2) ? 9'h002 : 9'h009, k[1:0], 3'h4}, 24);
		// direct words, then a test word that must change nothing
		for (int k = 0; k < 2; k++) begin
			r = rnd();
			spb_host_model_inst.send({8'h0, 10'h001, r[0], 1'b1, r[1], 3'h3}, 16);
			spb_host_model_inst.send({16'h0, r[6:2], 3'h5}, 8);
			spb_host_model_inst.send({8'h0, r[10:7], 5'h00, r[14:11], 3'h6}, 16);
			spb_host_model_inst.send({8'h0, r[27:15], 3'h7}, 16);
			chk_field("direct", {1'b0, r[0], r[1], r[6:2], r[10:7], r[14:11]}, {1'b0, imm});
			chk_snap("test word", act, snap);
		end
		// channel changes with buffered rewrites in between
		for (int k = 0; k < 5; k++) begin
			r = rnd();
			md = 12'd13 + 12'(r % 4083);
			mr = {md, r[3:0], r[4], r[5], r[6]};
			spb_host_model_inst.send({r[6], r[4], 1'b0, r[7], r[5], r[3:0], md, 3'h1}, 24);
			chk_field("prescaler", {15'h0, r[7]}, {15'h0, prescaler_sel});
			chk_snap("held modulus", act, snap);
			r = rnd();
			ph = r[11:0];
			spb_host_model_inst.send({8'h0, 1'b0, ph, 3'h2}, 16);
			chk_snap("held phase", act, snap);
			r = rnd();
			iv = 8'd26 + 8'(r % 230);
			fr = 12'(r[31:8] % md);
			act = {iv, fr, mr, ph};
			exp_q.push_back(act);
			spb_host_model_inst.send({1'b0, iv, fr, 3'h0}, 24);
		end
		// the last update may land after the frame ends, so let it arrive first
		repeat (20) @(posedge clk);
		for (int i = 0; i < 3000 && !(pump_cells === 7'h01 && filter_switch_c === 1'b0); i++)
			@(posedge clk);
		// one more edge so the length monitor sees the last fall
		@(posedge clk);
		chk_field("settled cells", 16'h0001, {9'h0, pump_cells});
		chk_field("switches", 16'h0, {13'h0, filter_switch_a, filter_switch_b, filter_switch_c});
		chk_field("unmatched", 16'h0, 16'(exp_q.size()));
		wrap_up;
	end
endmodule
